// [hw/strse_top.sv]
// What this block does
// - Condition-valid bit 24 is 1 for traps from the wide state.
// - Fixed-width narrow insn sets valid; compact insn value is a choice.
// - Condition field 23:20 is 0xe for traps from the wide state.
// - Fixed-width: own condition if conditional, else 0xe.
// - Passing conditional fixed-width insn may report 0xe or its condition.
// - Compact insn: valid clear with undefined field, or valid with condition.
// - Bits 19:17 hold selector b; 000 for fp register read.
// - Bits 16:14 hold selector a; 111 for fp register read.
// - Bits 13:10 hold major number; fp read gives its register select.
// - Bits 9:5 hold wide view of transfer register unless specifier is 1111.
// - Specifier 1111, predictable: index reported as 11111.
// - Specifier 1111, unpredictable: 11111 or a usable register's view.
// - Bits 4:1 hold minor number; 0000 for fp register read.
// - Bit 0 is 0 for write, 1 for read or fp read.
// - Syndrome fields have no defined value after warm reset.
// - Trapped coprocessor 1111 moves report class 000011.
// - Trapped coprocessor 1110 moves report class 000101.
// - Trapped fp id group 0/3 reads report class 001000 to hypervisor.
// - Per-register hypervisor trap bits trap coprocessor 1111 accesses.
// - TLB maintenance trap control traps kernel-level maintenance to hypervisor.
//
// Purpose: Records the syndrome of trapped register-move instructions
// Assumes: Pipeline offers each candidate trap as a one-cycle pulse
// Notes:   Registers on a plain strobe port, read data one cycle later
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module strse_top
   import strse_pkg::*;
(
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rst_b,
   // Candidate trap from pipeline
   input  wire logic             cand_valid,
   input  wire logic [1:0]       cand_kind,
   input  wire logic             cand_from_wide,
   input  wire logic             cand_compact,
   input  wire logic             cand_conditional,
   input  wire logic [3:0]       cand_predicate_code,
   input  wire logic [3:0]       cand_compact_predicate_code,
   input  wire logic             cand_predicate_code_passed,
   input  wire logic [3:0]       cand_coproc,
   input  wire logic [2:0]       operation_sel_b,
   input  wire logic [2:0]       operation_sel_a,
   input  wire logic [3:0]       sysreg_major,
   input  wire logic [3:0]       sysreg_minor,
   input  wire logic [3:0]       cand_fp_reg_sel,
   input  wire logic [3:0]       cand_gpr_spec,
   input  wire logic [4:0]       cand_gpr_wide,
   input  wire logic             cand_unpredictable,
   input  wire logic [4:0]       cand_unpred_gpr,
   input  wire logic             cand_at_kernel,
   input  wire logic             cand_tlb_maint,
   input  wire logic             cand_id_group0,
   input  wire logic             cand_id_group3,
   input  wire logic             cand_other_trap,
   // Trap commit to exception entry
   output logic                  trap_taken_q,
   output logic                  trap_to_hyp_q,
   // Register port
   input  wire logic [3:0]       reg_addr,
   input  wire logic [31:0]      reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   output logic [31:0]           reg_rdata_q
);
   logic [SYN_W-1:0] syndrome_q;
   logic [5:0]       class_q;
   logic [5:0]       ctrl_q;
   logic [15:0]      hstr_q;
   logic [7:0]       trap_count_q;
   logic [SYN_W-1:0] syn_d;
   logic [5:0]       class_d;
   logic             hstr_hit;
   logic             ttlb_hit;
   logic             fp_hit;
   logic             hyp_hit;
   logic             trap_d;

   strse_field_pack u_pack (
      .kind             (cand_kind),
      .from_wide_state  (cand_from_wide),
      .compact_insn     (cand_compact),
      .is_conditional   (cand_conditional),
      .insn_predicate_code        (cand_predicate_code),
      .compact_predicate_code     (cand_compact_predicate_code),
      .predicate_code_passed      (cand_predicate_code_passed),
      .coproc_num       (cand_coproc),
      .operation_sel_b  (operation_sel_b),
      .operation_sel_a  (operation_sel_a),
      .sysreg_major     (sysreg_major),
      .sysreg_minor     (sysreg_minor),
      .fp_reg_sel       (cand_fp_reg_sel),
      .gpr_spec         (cand_gpr_spec),
      .gpr_wide_view    (cand_gpr_wide),
      .unpredictable    (cand_unpredictable),
      .unpred_gpr_index (cand_unpred_gpr),
      .narrow_pv        (ctrl_q[CTRL_NARROW_PV]),
      .pass_always      (ctrl_q[CTRL_PASS_ALWAYS]),
      .syndrome         (syn_d),
      .exception_class  (class_d)
   );

   // Hypervisor trap decisions
   always_comb
   begin
      hstr_hit = ctrl_q[CTRL_HSTR_EN] && (cand_kind != STRSE_KIND_FP_READ)
                 && (cand_coproc == CP_SYSTEM)
                 && hstr_q[sysreg_major];
      ttlb_hit = ctrl_q[CTRL_TTLB] && cand_tlb_maint && cand_at_kernel
                 && (cand_coproc == CP_SYSTEM)
                 && (cand_kind != STRSE_KIND_FP_READ);
      fp_hit   = (cand_kind == STRSE_KIND_FP_READ)
                 && ((ctrl_q[CTRL_TID0] && cand_id_group0)
                 || (ctrl_q[CTRL_TID3] && cand_id_group3));
      hyp_hit  = hstr_hit || ttlb_hit || fp_hit;
      trap_d   = cand_valid && (hyp_hit || (cand_other_trap
                 && (cand_kind != STRSE_KIND_FP_READ)));
   end

   // Syndrome capture, no reset so fields are unknown until a trap or a software write
   always_ff @(posedge sys_clk)
   begin
      if (trap_d)
      begin
         syndrome_q <= syn_d;
         class_q    <= class_d;
      end
      else if (reg_wr && reg_addr == ADDR_SYNDROME)
         syndrome_q <= reg_wdata[SYN_W-1:0];
   end

   // Commit pulse to exception entry
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         trap_taken_q  <= 1'b0;
         trap_to_hyp_q <= 1'b0;
      end
      else
      begin
         trap_taken_q  <= trap_d;
         trap_to_hyp_q <= trap_d && hyp_hit;
      end
   end

   // Control and per-register trap bits
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         ctrl_q <= CTRL_RESET;
         hstr_q <= HSTR_RESET;
      end
      else if (reg_wr && reg_addr == ADDR_CTRL)
      begin
         ctrl_q <= reg_wdata[5:0];
         hstr_q <= reg_wdata[31:16];
      end
   end

   // Saturating count of captured traps, shown in status
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         trap_count_q <= 8'h00;
      else if (trap_d && trap_count_q != 8'hff)
         trap_count_q <= trap_count_q + 8'h01;
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         reg_rdata_q <= 32'h0000_0000;
      else if (reg_rd)
      begin
         case (reg_addr)
            ADDR_SYNDROME: reg_rdata_q <= {7'h00, syndrome_q};
            ADDR_CLASS:    reg_rdata_q <= {26'h0000000, class_q};
            ADDR_CTRL:     reg_rdata_q <= {hstr_q, 10'h000, ctrl_q};
            ADDR_STATUS:   reg_rdata_q <= {24'h000000, trap_count_q};
            default:       reg_rdata_q <= 32'h0000_0000;
         endcase
      end
      else
         reg_rdata_q <= 32'h0000_0000;
   end
endmodule // strse_top

// [hw/strse_pkg.sv]
// Purpose: Shared constants for the register-move trap syndrome encoder
// Assumes: 32-bit register port, word addresses as listed here
// Notes:   Field positions follow the 25-bit syndrome layout
package strse_pkg;

   // Syndrome field positions
   localparam int unsigned SYN_W        = 25;
   localparam int unsigned PV_BIT       = 24;
   localparam int unsigned PC_LSB       = 20;
   localparam int unsigned OSB_LSB      = 17;
   localparam int unsigned OSA_LSB      = 14;
   localparam int unsigned MAJ_LSB      = 10;
   localparam int unsigned GPR_LSB      = 5;
   localparam int unsigned MIN_LSB      = 1;
   localparam int unsigned DIR_BIT      = 0;

   // Fixed field values
   localparam logic [3:0] PREDICATE_CODE_ALWAYS   = 4'he;
   localparam logic [2:0] FP_OSB        = 3'h0;
   localparam logic [2:0] FP_OSA        = 3'h7;
   localparam logic [3:0] FP_MINOR      = 4'h0;
   localparam logic [3:0] GPR_PC_SPEC   = 4'hf;
   localparam logic [4:0] GPR_ZR_INDEX  = 5'h1f;
   localparam logic       DIR_WRITE     = 1'b0;
   localparam logic       DIR_READ      = 1'b1;

   // Coprocessor numbers and exception classes
   localparam logic [3:0] CP_SYSTEM     = 4'hf;
   localparam logic [3:0] CP_DEBUG      = 4'he;
   localparam logic [5:0] EC_CP15_MOVE  = 6'h03;
   localparam logic [5:0] EC_CP14_MOVE  = 6'h05;
   localparam logic [5:0] EC_FP_ID_READ = 6'h08;
   localparam logic [5:0] EC_NONE       = 6'h00;

   // Register port map (word addresses)
   localparam logic [3:0] ADDR_SYNDROME = 4'h0;
   localparam logic [3:0] ADDR_CLASS    = 4'h1;
   localparam logic [3:0] ADDR_CTRL     = 4'h2;
   localparam logic [3:0] ADDR_STATUS   = 4'h3;

   // Control register bits
   localparam int unsigned CTRL_NARROW_PV   = 0;
   localparam int unsigned CTRL_PASS_ALWAYS = 1;
   localparam int unsigned CTRL_HSTR_EN     = 2;
   localparam int unsigned CTRL_TTLB        = 3;
   localparam int unsigned CTRL_TID0        = 4;
   localparam int unsigned CTRL_TID3        = 5;
   localparam logic [5:0]  CTRL_RESET       = 6'h00;
   localparam logic [15:0] HSTR_RESET       = 16'h0000;

   typedef enum logic [1:0] {
      STRSE_KIND_WRITE,
      STRSE_KIND_READ,
      STRSE_KIND_FP_READ
   } strse_kind_e;

endpackage

// [hw/strse_field_pack.sv]
// Purpose: Combinational packing of one trap syndrome word and class
// Assumes: Inputs stable in the commit cycle
// Notes:   Registered by the caller
`timescale 1ns/1ps
module strse_field_pack
   import strse_pkg::*;
(
   // Trap description
   input  wire logic [1:0]       kind,
   input  wire logic             from_wide_state,
   input  wire logic             compact_insn,
   input  wire logic             is_conditional,
   input  wire logic [3:0]       insn_predicate_code,
   input  wire logic [3:0]       compact_predicate_code,
   input  wire logic             predicate_code_passed,
   input  wire logic [3:0]       coproc_num,
   input  wire logic [2:0]       operation_sel_b,
   input  wire logic [2:0]       operation_sel_a,
   input  wire logic [3:0]       sysreg_major,
   input  wire logic [3:0]       sysreg_minor,
   input  wire logic [3:0]       fp_reg_sel,
   input  wire logic [3:0]       gpr_spec,
   input  wire logic [4:0]       gpr_wide_view,
   input  wire logic             unpredictable,
   input  wire logic [4:0]       unpred_gpr_index,
   // Policy
   input  wire logic             narrow_pv,
   input  wire logic             pass_always,
   // Result
   output logic [SYN_W-1:0]      syndrome,
   output logic [5:0]            exception_class
);
   logic       pv;
   logic [3:0] pc;
   logic [2:0] osb;
   logic [2:0] osa;
   logic [3:0] maj;
   logic [3:0] mnr;
   logic [4:0] gpr;
   logic       dir;
   logic       fp;

   always_comb
   begin
      fp = (kind == STRSE_KIND_FP_READ);
      if (from_wide_state)
      begin
         pv = 1'b1;
         pc = PREDICATE_CODE_ALWAYS;
      end
      else if (compact_insn)
      begin
         pv = !narrow_pv;
         pc = narrow_pv ? PREDICATE_CODE_ALWAYS : compact_predicate_code;
      end
      else
      begin
         pv = 1'b1;
         if (!is_conditional || (pass_always && predicate_code_passed))
            pc = PREDICATE_CODE_ALWAYS;
         else
            pc = insn_predicate_code;
      end
      osb = fp ? FP_OSB : operation_sel_b;
      osa = fp ? FP_OSA : operation_sel_a;
      maj = fp ? fp_reg_sel : sysreg_major;
      mnr = fp ? FP_MINOR : sysreg_minor;
      if (gpr_spec != GPR_PC_SPEC)
         gpr = gpr_wide_view;
      else if (!unpredictable)
         gpr = GPR_ZR_INDEX;
      else
         gpr = unpred_gpr_index;
      dir = (kind == STRSE_KIND_WRITE) ? DIR_WRITE : DIR_READ;
      syndrome = {pv, pc, osb, osa, maj, gpr, mnr, dir};
      if (fp)
         exception_class = EC_FP_ID_READ;
      else if (coproc_num == CP_SYSTEM)
         exception_class = EC_CP15_MOVE;
      else if (coproc_num == CP_DEBUG)
         exception_class = EC_CP14_MOVE;
      else
         exception_class = EC_NONE;
   end
endmodule // strse_field_pack

// [tb/strse_properties.sv]
// Purpose: Port properties of the trap syndrome encoder
// Assumes: Syndrome read in the cycle after a candidate
// Notes:   Hyp traps hang on ctrl, so only fixed causes are tied here
`timescale 1ns/1ps
module strse_properties
   import strse_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        rst_b,
   input wire logic        cand_valid,
   input wire logic [1:0]  cand_kind,
   input wire logic        cand_from_wide,
   input wire logic        cand_other_trap,
   input wire logic        cand_id_group0,
   input wire logic        cand_id_group3,
   input wire logic [3:0]  cand_fp_reg_sel,
   input wire logic [2:0]  operation_sel_b,
   input wire logic [2:0]  operation_sel_a,
   input wire logic [3:0]  sysreg_major,
   input wire logic [3:0]  sysreg_minor,
   input wire logic        trap_taken_q,
   input wire logic        trap_to_hyp_q,
   input wire logic [3:0]  reg_addr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata_q
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   sequence s_move;
      cand_valid && cand_other_trap && cand_kind != 2'h2;
   endsequence
   sequence s_syn_rd;
      reg_rd && reg_addr == ADDR_SYNDROME;
   endsequence
   chk_move_taken: assert property (s_move |=> trap_taken_q)
      else $error("move trap missed");
   chk_no_spurious: assert property (!cand_valid |=> !trap_taken_q)
      else $error("trap without candidate");
   chk_hyp_taken: assert property (trap_to_hyp_q |-> trap_taken_q)
      else $error("hyp pulse alone");
   chk_fp_id_only: assert property (
      cand_valid && cand_kind == 2'h2 && !cand_id_group0 && !cand_id_group3 |=> !trap_taken_q)
      else $error("fp read trapped without id group");
   chk_rd_idle: assert property (!reg_rd |=> reg_rdata_q == 32'h0)
      else $error("read data outside its cycle");
   chk_wide_predicate_code: assert property (
      s_move ##0 cand_from_wide ##1 s_syn_rd |=> reg_rdata_q[24:20] == 5'h1e)
      else $error("wide state predicate wrong");
   chk_move_fields: assert property (s_move ##1 s_syn_rd |=>
      reg_rdata_q[19:10] == {$past(operation_sel_b, 2), $past(operation_sel_a, 2),
      $past(sysreg_major, 2)} && reg_rdata_q[4:0] == {$past(sysreg_minor, 2),
      $past(cand_kind, 2) == 2'h1}) else $error("move fields wrong");
   chk_fp_fields: assert property (
      cand_valid && cand_kind == 2'h2 ##1 trap_taken_q ##0 s_syn_rd |=> reg_rdata_q[4:0]
      == 5'h01 && reg_rdata_q[19:10] == {6'h07, $past(cand_fp_reg_sel, 2)})
      else $error("fp read fields wrong");
   // Floating-point reads only ever trap through the hypervisor id controls
   chk_fp_to_hyp: assert property (
      cand_valid && cand_kind == 2'h2 |=> trap_taken_q == trap_to_hyp_q)
      else $error("fp read trap not sent to hypervisor");
endmodule // strse_properties

// [tb/strse_handler.sv]
// Purpose: Exception handler stand-in counting trap entries
// Assumes: Entry pulses last one cycle each
// Notes:   Counts are compared against the bench model
`timescale 1ns/1ps
module strse_handler
(
   input  wire logic sys_clk,
   input  wire logic rst_b,
   input  wire logic trap_taken_q,
   input  wire logic trap_to_hyp_q,
   output int        n_entries,
   output int        n_hyp_entries
);
   always_ff @(posedge sys_clk)
   begin
      n_entries     <= rst_b ? n_entries + int'(trap_taken_q) : 0;
      n_hyp_entries <= rst_b ? n_hyp_entries + int'(trap_to_hyp_q) : 0;
   end
endmodule // strse_handler

// [tb/strse_top_bench.sv]
// Purpose: Self-checking bench for the trap syndrome encoder
// Assumes: Plain strobe register port, read data one cycle later
// Notes:   Syndrome has no reset value, so it is written before first use
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
   $display("unexpected %s exp %h got %h", nm, e, g); mismatches++; end end
module strse_top_bench
   import strse_pkg::*;
;
   logic sys_clk, rst_b, cand_valid, cand_from_wide, cand_compact, cand_conditional;
   logic cand_predicate_code_passed, cand_unpredictable, cand_at_kernel, cand_tlb_maint;
   logic cand_id_group0, cand_id_group3, cand_other_trap, reg_wr, reg_rd;
   logic trap_taken_q, trap_to_hyp_q, hyp, take;
   logic [1:0]  cand_kind;
   logic [2:0]  operation_sel_b, operation_sel_a;
   logic [3:0]  cand_predicate_code, cand_compact_predicate_code, cand_coproc, sysreg_major, sysreg_minor;
   logic [3:0]  cand_fp_reg_sel, cand_gpr_spec, reg_addr;
   logic [4:0]  cand_gpr_wide, cand_unpred_gpr;
   logic [31:0] reg_wdata, reg_rdata_q, ctrl, d;
   logic [24:0] exp_syn;
   logic [5:0]  exp_cls;
   int          mismatches, n_checks, cycles, n_trap, n_hyp, n_entries, n_hyp_entries;
   strse_top DUT (.sys_clk, .rst_b, .cand_valid, .cand_kind, .cand_from_wide, .cand_compact,
      .cand_conditional, .cand_predicate_code, .cand_compact_predicate_code, .cand_predicate_code_passed, .cand_coproc,
      .operation_sel_b, .operation_sel_a, .sysreg_major, .sysreg_minor, .cand_fp_reg_sel,
      .cand_gpr_spec, .cand_gpr_wide, .cand_unpredictable, .cand_unpred_gpr, .cand_at_kernel,
      .cand_tlb_maint, .cand_id_group0, .cand_id_group3, .cand_other_trap, .trap_taken_q,
      .trap_to_hyp_q, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q);
   strse_handler u_handler (.sys_clk, .rst_b, .trap_taken_q, .trap_to_hyp_q, .n_entries,
      .n_hyp_entries);
   initial
   begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Ceiling sized for about 600 cycles of traffic
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         mismatches++;
         complete_run();
      end
   end
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(posedge sys_clk);
      v = reg_rdata_q;
   endtask
   function automatic logic [24:0] model();
      logic [3:0] cd;
      logic       pv;
      logic [4:0] g;
      pv = 1'b1;
      cd = cand_conditional && !(cand_predicate_code_passed && ctrl[1]) ? cand_predicate_code : 4'he;
      if (cand_from_wide)
         cd = 4'he;
      else if (cand_compact)
      begin
         pv = !ctrl[0];
         cd = ctrl[0] ? 4'he : cand_compact_predicate_code;
      end
      g = cand_gpr_spec != 4'hf ? cand_gpr_wide : (cand_unpredictable ? cand_unpred_gpr : 5'h1f);
      if (cand_kind == 2'h2)
         return {pv, cd, 3'h0, 3'h7, cand_fp_reg_sel, g, 4'h0, 1'b1};
      return {pv, cd, operation_sel_b, operation_sel_a, sysreg_major, g, sysreg_minor,
         cand_kind == 2'h1};
   endfunction
   initial
   begin
      {rst_b, cand_valid, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      {cand_kind, cand_coproc, cand_gpr_wide, cand_unpred_gpr} = '0;
      {cand_from_wide, cand_compact, cand_conditional, cand_predicate_code_passed, cand_unpredictable,
         cand_at_kernel, cand_tlb_maint, cand_id_group0, cand_id_group3, cand_other_trap,
         cand_predicate_code, cand_compact_predicate_code, operation_sel_b, operation_sel_a, sysreg_major,
         sysreg_minor, cand_fp_reg_sel, cand_gpr_spec} = '0;
      void'($urandom(3959));
      repeat (4) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      rd(ADDR_CTRL, d);
      `CHK("ctrl", 32'h0, d)
      wr(ADDR_SYNDROME, 32'hffff_ffff);
      rd(ADDR_SYNDROME, d);
      exp_syn = 25'h1ff_ffff;
      `CHK("syndrome rw", exp_syn, d[24:0])
      rd(4'h7, d);
      `CHK("unmapped", 32'h0, d)
      $display("test registers done");
      for (int i = 0; i < 80; i++)
      begin
         ctrl = $urandom();
         wr(ADDR_CTRL, ctrl);
         cand_valid <= 1'b1;
         cand_kind <= 2'($urandom_range(2));
         cand_coproc <= 4'($urandom_range(15, 13));
         {cand_from_wide, cand_compact, cand_conditional, cand_predicate_code_passed, cand_unpredictable,
            cand_at_kernel, cand_tlb_maint, cand_id_group0, cand_id_group3, cand_other_trap,
            cand_predicate_code, cand_compact_predicate_code, operation_sel_b, operation_sel_a, sysreg_major,
            sysreg_minor, cand_fp_reg_sel, cand_gpr_spec} <= 40'({$urandom(), $urandom()});
         {reg_wr, cand_gpr_wide, cand_unpred_gpr} <= 11'($urandom());
         // Class has no reset value, so the first pass must trap
         if (i == 0)
            {cand_kind, cand_other_trap} <= 3'h1;
         reg_wdata <= $urandom();
         reg_addr <= ADDR_SYNDROME;
         @(posedge sys_clk);
         hyp = (cand_kind != 2'h2 && cand_coproc == 4'hf && (ctrl[2] && ctrl[16 + sysreg_major]
            || ctrl[3] && cand_tlb_maint && cand_at_kernel)) || (cand_kind == 2'h2
            && (ctrl[4] && cand_id_group0 || ctrl[5] && cand_id_group3));
         take = hyp || (cand_other_trap && cand_kind != 2'h2);
         // Trap beats a same-cycle software write
         exp_syn = take ? model() : (reg_wr ? reg_wdata[24:0] : exp_syn);
         if (take)
            exp_cls = cand_kind == 2'h2 ? 6'h08 : cand_coproc == 4'hf ? 6'h03
               : cand_coproc == 4'he ? 6'h05 : 6'h00;
         n_trap += int'(take);
         n_hyp += int'(hyp);
         cand_valid <= 1'b0;
         reg_wr <= 1'b0;
         reg_rd <= 1'b1;
         @(posedge sys_clk);
         `CHK("taken", take, trap_taken_q)
         `CHK("to hyp", hyp, trap_to_hyp_q)
         reg_rd <= 1'b0;
         @(posedge sys_clk);
         `CHK("syndrome", exp_syn, reg_rdata_q[24:0])
         rd(ADDR_CLASS, d);
         `CHK("class", exp_cls, d[5:0])
      end
      $display("test traps done");
      wr(ADDR_CLASS, {26'h0, ~exp_cls});
      rd(ADDR_CLASS, d);
      `CHK("class ro", exp_cls, d[5:0])
      rd(ADDR_STATUS, d);
      `CHK("count", 8'(n_trap), d[7:0])
      `CHK("entries", n_trap, n_entries)
      `CHK("hyp entries", n_hyp, n_hyp_entries)
      rst_b <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      rd(ADDR_STATUS, d);
      `CHK("count reset", 32'h0, d)
      $display("test reset done");
      complete_run();
   end
endmodule // strse_top_bench
bind strse_top strse_properties u_props (.sys_clk, .rst_b, .cand_valid, .cand_kind,
   .cand_from_wide, .cand_other_trap, .cand_id_group0, .cand_id_group3, .cand_fp_reg_sel,
   .operation_sel_b, .operation_sel_a, .sysreg_major, .sysreg_minor, .trap_taken_q,
   .trap_to_hyp_q, .reg_addr, .reg_rd, .reg_rdata_q);
